// ==== els_clock_sync_counter.sv ====
// module: clock sync counter for server, fabric and client roles with an AHB-Lite register slave
//
// Added by the designer: register access over AHB-Lite and the address map.
module els_clock_sync_counter (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic rx_valid_in,
    input wire logic [31:0] rx_data_in,
    input wire logic rx_sof_in,
    input wire logic rx_eof_in,
    output logic tx_valid_out,
    output logic [31:0] tx_data_out,
    output logic tx_sof_out,
    output logic tx_eof_out,
    output logic [63:0] count_out,
    output logic init_capable_out,
    output logic recip_capable_out
);
    // ****************************************
    // functions
    // ****************************************
    function automatic logic [31:0] crc_word(input logic [31:0] crc, input logic [31:0] data);
        logic [31:0] c;
        c = crc;
        for (int i = 31; i >= 0; i--) begin
            c = (c[31] ^ data[i]) ? ((c << 1) ^ els_sync_pkg::CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    function automatic logic [31:0] server_word(input logic [3:0] idx, input logic [23:0] dest,
                                                input logic [63:0] value);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (idx)
            4'h0: w = {els_sync_pkg::ELS_RCTL, dest};
            4'h1: w = {8'h00, els_sync_pkg::SERVER_ID};
            4'h2: w = {els_sync_pkg::ELS_TYPE, els_sync_pkg::CSU_FCTL};
            4'h3: w = 32'h0000_0000;
            4'h4: w = 32'hFFFF_FFFF;
            4'h5: w = 32'h0000_0000;
            4'h6: w = {els_sync_pkg::CSU_CODE, 24'h00_0000};
            4'h7: w = value[63:32];
            4'h8: w = value[31:0];
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    // ****************************************
    // control registers and bus slave
    // ****************************************
    logic [3:0] ctrl_reg, ctrl_next;
    logic [31:0] period_reg, period_next;
    logic [15:0] div_reg, div_next;
    logic [23:0] dest_reg, dest_next;
    logic [23:0] qos_reg, qos_next;
    logic [31:0] delay_reg, delay_next;
    logic [31:0] csu_cnt_reg, csu_cnt_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic wr_pend_reg, wr_pend_next;
    logic [7:0] wr_addr_reg, wr_addr_next;
    logic [63:0] count;
    logic tick;
    logic load;
    logic [63:0] load_value;
    logic csu_event;
    logic gen_busy;
    logic rw_busy;
    els_sync_pkg::role_t role;
    logic enable;
    logic own_counter;
    logic addr_phase;

    assign role = els_sync_pkg::role_t'(ctrl_reg[els_sync_pkg::CTRL_ROLE_LSB +: 2]);
    assign enable = ctrl_reg[els_sync_pkg::CTRL_EN_BIT];
    assign own_counter = ctrl_reg[els_sync_pkg::CTRL_OWN_BIT];
    assign addr_phase = hsel_in && htrans_in[1] && hready_in;

    always_comb begin
        ctrl_next = ctrl_reg;
        period_next = period_reg;
        div_next = div_reg;
        dest_next = dest_reg;
        qos_next = qos_reg;
        delay_next = delay_reg;
        csu_cnt_next = csu_event ? csu_cnt_reg + 32'h0000_0001 : csu_cnt_reg;
        hrdata_next = hrdata_reg;
        wr_pend_next = addr_phase && hwrite_in;
        wr_addr_next = addr_phase ? {haddr_in[7:2], 2'b00} : wr_addr_reg;
        if (wr_pend_reg) begin
            unique case (wr_addr_reg)
                els_sync_pkg::OFS_CTRL: ctrl_next = hwdata_in[3:0];
                els_sync_pkg::OFS_PERIOD: period_next = hwdata_in;
                els_sync_pkg::OFS_TICK_DIV: div_next = hwdata_in[15:0];
                els_sync_pkg::OFS_DEST_ID: dest_next = hwdata_in[23:0];
                els_sync_pkg::OFS_QOS: qos_next = hwdata_in[23:0];
                els_sync_pkg::OFS_DELAY: delay_next = hwdata_in;
                default: ;
            endcase
        end
        if (addr_phase && !hwrite_in) begin
            unique case ({haddr_in[7:2], 2'b00})
                els_sync_pkg::OFS_CTRL: hrdata_next = {28'h000_0000, ctrl_reg};
                els_sync_pkg::OFS_STATUS: hrdata_next = {28'h000_0000, recip_capable_out,
                                                         init_capable_out, rw_busy, gen_busy};
                els_sync_pkg::OFS_COUNT_HI: hrdata_next = count[63:32];
                els_sync_pkg::OFS_COUNT_LO: hrdata_next = count[31:0];
                els_sync_pkg::OFS_PERIOD: hrdata_next = period_reg;
                els_sync_pkg::OFS_TICK_DIV: hrdata_next = {16'h0000, div_reg};
                els_sync_pkg::OFS_DEST_ID: hrdata_next = {8'h00, dest_reg};
                els_sync_pkg::OFS_QOS: hrdata_next = {8'h00, qos_reg};
                els_sync_pkg::OFS_DELAY: hrdata_next = delay_reg;
                els_sync_pkg::OFS_CSU_COUNT: hrdata_next = csu_cnt_reg;
                default: hrdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            ctrl_reg <= els_sync_pkg::CTRL_RESET;
            period_reg <= els_sync_pkg::PERIOD_RESET;
            div_reg <= els_sync_pkg::TICK_DIV_RESET;
            dest_reg <= els_sync_pkg::DEST_RESET;
            qos_reg <= els_sync_pkg::QOS_RESET;
            delay_reg <= els_sync_pkg::DELAY_RESET;
            csu_cnt_reg <= 32'h0000_0000;
            hrdata_reg <= 32'h0000_0000;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            ctrl_reg <= ctrl_next;
            period_reg <= period_next;
            div_reg <= div_next;
            dest_reg <= dest_next;
            qos_reg <= qos_next;
            delay_reg <= delay_next;
            csu_cnt_reg <= csu_cnt_next;
            hrdata_reg <= hrdata_next;
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
        end
    end

    // zero wait states, always OKAY
    assign hrdata_out = hrdata_reg;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign init_capable_out = enable && (role == els_sync_pkg::ROLE_SERVER);
    assign recip_capable_out = enable && (role == els_sync_pkg::ROLE_FABRIC
                                          || role == els_sync_pkg::ROLE_CLIENT);

    // ****************************************
    // local counter
    // ****************************************
    sync_counter u_counter (
        .mclk_in(mclk_in),
        .resetn_in(resetn_in),
        .enable_in(enable),
        .div_in(div_reg),
        .load_in(load),
        .load_value_in(load_value),
        .count_out(count),
        .tick_out(tick)
    );
    assign count_out = count;

    // ****************************************
    // receive parse and two-stage delay line
    // ****************************************
    // frames must arrive with rx_valid high on every word from sof to eof
    logic [3:0] rx_idx_reg, rx_idx_next;
    logic rx_match_reg, rx_match_next;
    logic [31:0] rx_hi_reg, rx_hi_next;
    logic [31:0] d_data_reg [0:1];
    logic [31:0] d_data_next [0:1];
    logic [1:0] d_valid_reg, d_valid_next;
    logic [1:0] d_sof_reg, d_sof_next;
    logic [1:0] d_eof_reg, d_eof_next;
    logic [3:0] cur_idx;
    logic csu_done;

    always_comb begin
        cur_idx = rx_sof_in ? 4'h0 : ((rx_idx_reg == els_sync_pkg::IDX_MAX) ? rx_idx_reg : rx_idx_reg + 4'h1);
        rx_idx_next = rx_valid_in ? cur_idx : rx_idx_reg;
        rx_match_next = rx_match_reg;
        rx_hi_next = rx_hi_reg;
        if (rx_valid_in) begin
            if (cur_idx == 4'h0) begin
                rx_match_next = (rx_data_in[31:24] == els_sync_pkg::ELS_RCTL);
            end else if (cur_idx == els_sync_pkg::IDX_CMD) begin
                rx_match_next = rx_match_reg && (rx_data_in[31:24] == els_sync_pkg::CSU_CODE);
            end else if (cur_idx == els_sync_pkg::IDX_HI) begin
                rx_hi_next = rx_data_in;
            end
        end
        d_data_next[0] = rx_data_in;
        d_data_next[1] = d_data_reg[0];
        d_valid_next = {d_valid_reg[0], rx_valid_in};
        d_sof_next = {d_sof_reg[0], rx_valid_in && rx_sof_in};
        d_eof_next = {d_eof_reg[0], rx_valid_in && rx_eof_in};
    end

    // a complete CSU: matching header and command, eof exactly on the crc word
    assign csu_done = rx_valid_in && rx_eof_in && rx_match_reg && (cur_idx == els_sync_pkg::IDX_CRC)
                      && role != els_sync_pkg::ROLE_SERVER && enable;
    // destination is not checked, so a client, or a fabric with its own-counter bit set, takes every CSU
    assign load = csu_done && (role != els_sync_pkg::ROLE_FABRIC || own_counter);
    assign load_value = (role == els_sync_pkg::ROLE_FABRIC) ? {rx_hi_reg, d_data_reg[0]}
                      : {rx_hi_reg, d_data_reg[0]} + {32'h0000_0000, delay_reg};

    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            rx_idx_reg <= els_sync_pkg::IDX_MAX;
            rx_match_reg <= 1'b0;
            rx_hi_reg <= 32'h0000_0000;
            d_data_reg[0] <= 32'h0000_0000;
            d_data_reg[1] <= 32'h0000_0000;
            d_valid_reg <= 2'b00;
            d_sof_reg <= 2'b00;
            d_eof_reg <= 2'b00;
        end else begin
            rx_idx_reg <= rx_idx_next;
            rx_match_reg <= rx_match_next;
            rx_hi_reg <= rx_hi_next;
            d_data_reg[0] <= d_data_next[0];
            d_data_reg[1] <= d_data_next[1];
            d_valid_reg <= d_valid_next;
            d_sof_reg <= d_sof_next;
            d_eof_reg <= d_eof_next;
        end
    end

    // ****************************************
    // server generator and transmit path
    // ****************************************
    els_sync_pkg::gen_state_t gen_state_reg, gen_state_next;
    logic [31:0] period_cnt_reg, period_cnt_next;
    logic [3:0] gen_idx_reg, gen_idx_next;
    logic [63:0] snap_reg, snap_next;
    logic [1:0] rw_pos_reg, rw_pos_next;
    logic [31:0] crc_reg, crc_next;
    logic tx_valid_reg, tx_valid_next;
    logic [31:0] tx_data_reg, tx_data_next;
    logic tx_sof_reg, tx_sof_next;
    logic tx_eof_reg, tx_eof_next;
    logic [31:0] word;

    assign gen_busy = (gen_state_reg == els_sync_pkg::GEN_SEND);
    assign rw_busy = (rw_pos_reg != 2'b00);
    assign csu_event = csu_done || (gen_busy && gen_idx_reg == els_sync_pkg::IDX_CRC);

    always_comb begin
        gen_state_next = gen_state_reg;
        period_cnt_next = period_cnt_reg;
        gen_idx_next = gen_idx_reg;
        snap_next = snap_reg;
        rw_pos_next = rw_pos_reg;
        crc_next = crc_reg;
        tx_valid_next = 1'b0;
        tx_data_next = tx_data_reg;
        tx_sof_next = 1'b0;
        tx_eof_next = 1'b0;
        word = 32'h0000_0000;
        if (role == els_sync_pkg::ROLE_SERVER) begin
            // period counts local ticks, so the update period follows the tick divider
            if (enable && tick && !gen_busy) begin
                period_cnt_next = (period_cnt_reg >= period_reg) ? 32'h0000_0000 : period_cnt_reg + 32'h0000_0001;
            end
            unique case (gen_state_reg)
                els_sync_pkg::GEN_IDLE: begin
                    if (enable && tick && period_cnt_reg >= period_reg) begin
                        gen_state_next = els_sync_pkg::GEN_SEND;
                        gen_idx_next = 4'h0;
                        snap_next = count;
                    end
                end
                els_sync_pkg::GEN_SEND: begin
                    if (gen_idx_reg == els_sync_pkg::IDX_CRC) begin
                        word = ~crc_reg;
                        gen_state_next = els_sync_pkg::GEN_IDLE;
                    end else begin
                        word = server_word(gen_idx_reg, dest_reg, snap_reg);
                        crc_next = crc_word((gen_idx_reg == 4'h0) ? els_sync_pkg::CRC_INIT : crc_reg, word);
                        gen_idx_next = gen_idx_reg + 4'h1;
                    end
                    tx_valid_next = 1'b1;
                    tx_data_next = word;
                    tx_sof_next = (gen_idx_reg == 4'h0);
                    tx_eof_next = (gen_idx_reg == els_sync_pkg::IDX_CRC);
                end
            endcase
        end else begin
            gen_state_next = els_sync_pkg::GEN_IDLE;
            period_cnt_next = 32'h0000_0000;
            // every word is forwarded unchanged unless a rewrite is under way
            word = d_data_reg[1];
            if (csu_done && role == els_sync_pkg::ROLE_FABRIC && own_counter) begin
                // counter is loaded on this same edge, so the fresh payload is the value it takes
                snap_next = load_value;
                word = load_value[63:32];
                rw_pos_next = 2'b01;
            end else if (rw_pos_reg == 2'b01) begin
                word = snap_reg[31:0];
                rw_pos_next = 2'b10;
            end else if (rw_pos_reg == 2'b10) begin
                word = ~crc_reg;
                rw_pos_next = 2'b00;
            end
            if (d_valid_reg[1]) begin
                crc_next = crc_word(d_sof_reg[1] ? els_sync_pkg::CRC_INIT : crc_reg, word);
            end
            tx_valid_next = d_valid_reg[1];
            tx_data_next = word;
            tx_sof_next = d_sof_reg[1];
            tx_eof_next = d_eof_reg[1];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            gen_state_reg <= els_sync_pkg::GEN_IDLE;
            period_cnt_reg <= 32'h0000_0000;
            gen_idx_reg <= 4'h0;
            snap_reg <= 64'h0000_0000_0000_0000;
            rw_pos_reg <= 2'b00;
            crc_reg <= els_sync_pkg::CRC_INIT;
            tx_valid_reg <= 1'b0;
            tx_data_reg <= 32'h0000_0000;
            tx_sof_reg <= 1'b0;
            tx_eof_reg <= 1'b0;
        end else begin
            gen_state_reg <= gen_state_next;
            period_cnt_reg <= period_cnt_next;
            gen_idx_reg <= gen_idx_next;
            snap_reg <= snap_next;
            rw_pos_reg <= rw_pos_next;
            crc_reg <= crc_next;
            tx_valid_reg <= tx_valid_next;
            tx_data_reg <= tx_data_next;
            tx_sof_reg <= tx_sof_next;
            tx_eof_reg <= tx_eof_next;
        end
    end

    assign tx_valid_out = tx_valid_reg;
    assign tx_data_out = tx_data_reg;
    assign tx_sof_out = tx_sof_reg;
    assign tx_eof_out = tx_eof_reg;
endmodule

// ==== els_sync_monitor.sv ====
// checker: port timing properties of the clock sync counter
module els_sync_monitor (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic rx_valid_in,
    input wire logic [31:0] rx_data_in,
    input wire logic rx_sof_in,
    input wire logic rx_eof_in,
    input wire logic tx_valid_out,
    input wire logic [31:0] tx_data_out,
    input wire logic tx_sof_out,
    input wire logic tx_eof_out,
    input wire logic [63:0] count_out,
    input wire logic init_capable_out,
    input wire logic recip_capable_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_ten;
        tx_valid_out [*8] ##1 tx_valid_out ##1 (tx_valid_out && tx_eof_out);
    endsequence
    sequence s_hdr;
        tx_data_out[31:24] == els_sync_pkg::ELS_RCTL ##1 tx_data_out[23:0] == els_sync_pkg::SERVER_ID;
    endsequence
    property p_frame; tx_sof_out |-> s_ten; endproperty
    a_frame: assert property (p_frame) else $error("tx frame not ten words");
    property p_fwd; rx_valid_in && rx_sof_in && recip_capable_out |-> ##3 tx_sof_out && tx_data_out == $past(rx_data_in, 3); endproperty
    a_fwd: assert property (p_fwd) else $error("frame start not relayed");
    property p_inc; $changed(count_out) && !$past(rx_eof_in) |-> count_out == $past(count_out) + 64'h1; endproperty
    a_inc: assert property (p_inc) else $error("counter step wrong");
    property p_cap; init_capable_out |-> !recip_capable_out; endproperty
    a_cap: assert property (p_cap) else $error("both capable bits set");
    property p_hdr; init_capable_out && tx_sof_out |-> s_hdr; endproperty
    a_hdr: assert property (p_hdr) else $error("server header wrong");
    property p_cmd; init_capable_out && tx_sof_out |-> ##6 tx_data_out[31:24] == els_sync_pkg::CSU_CODE; endproperty
    a_cmd: assert property (p_cmd) else $error("server command code wrong");
    property p_quiet; !tx_valid_out |-> !(tx_sof_out || tx_eof_out); endproperty
    a_quiet: assert property (p_quiet) else $error("marker without valid");
    property p_eof; tx_eof_out |=> !tx_eof_out; endproperty
    a_eof: assert property (p_eof) else $error("end marker too long");
endmodule
bind els_clock_sync_counter els_sync_monitor u_mon (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in), .rx_sof_in(rx_sof_in), .rx_eof_in(rx_eof_in),
    .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out), .tx_sof_out(tx_sof_out), .tx_eof_out(tx_eof_out),
    .count_out(count_out), .init_capable_out(init_capable_out), .recip_capable_out(recip_capable_out));

// ==== els_sync_pkg.sv ====
// package: constants, offsets and types shared by the clock sync counter block
package els_sync_pkg;
    // ****************************************
    // widths and frame layout
    // ****************************************
    localparam int COUNT_W = 64;
    localparam int WORD_W = 32;
    localparam logic [3:0] IDX_LAST_HDR = 4'h5;
    localparam logic [3:0] IDX_CMD = 4'h6;
    localparam logic [3:0] IDX_HI = 4'h7;
    localparam logic [3:0] IDX_LO = 4'h8;
    localparam logic [3:0] IDX_CRC = 4'h9;
    localparam logic [3:0] IDX_MAX = 4'hF;
    // ****************************************
    // frame field values
    // ****************************************
    localparam logic [23:0] SERVER_ID = 24'hFF_FFF6;
    localparam logic [7:0] ELS_RCTL = 8'h22;
    localparam logic [7:0] ELS_TYPE = 8'h01;
    localparam logic [7:0] CSU_CODE = 8'h01;
    localparam logic [23:0] CSU_FCTL = 24'h00_0000;
    localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
    localparam logic [31:0] CRC_POLY = 32'h04C1_1DB7;
    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_COUNT_HI = 8'h08;
    localparam logic [7:0] OFS_COUNT_LO = 8'h0C;
    localparam logic [7:0] OFS_PERIOD = 8'h10;
    localparam logic [7:0] OFS_TICK_DIV = 8'h14;
    localparam logic [7:0] OFS_DEST_ID = 8'h18;
    localparam logic [7:0] OFS_QOS = 8'h1C;
    localparam logic [7:0] OFS_DELAY = 8'h20;
    localparam logic [7:0] OFS_CSU_COUNT = 8'h24;
    // ****************************************
    // control fields
    // ****************************************
    localparam int CTRL_ROLE_LSB = 0;
    localparam int CTRL_EN_BIT = 2;
    localparam int CTRL_OWN_BIT = 3;
    // ****************************************
    // reset values and timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int TICK_PERIOD_NS = 1000;
    localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [31:0] PERIOD_RESET = 32'h0000_1000;
    localparam logic [15:0] TICK_DIV_RESET = 16'(TICK_CYCLES - 1);
    localparam logic [23:0] DEST_RESET = 24'hFF_FFFF;
    localparam logic [23:0] QOS_RESET = 24'h00_3F00;
    localparam logic [31:0] DELAY_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        ROLE_CLIENT = 2'b00,
        ROLE_FABRIC = 2'b01,
        ROLE_SERVER = 2'b11
    } role_t;

    typedef enum logic {
        GEN_IDLE = 1'b0,
        GEN_SEND = 1'b1
    } gen_state_t;
endpackage

// ==== far_port.sv ====
// model: far port that feeds ELS frames into the receive side
module far_port (
    input wire logic mclk_in,
    output logic valid_out,
    output logic [31:0] data_out,
    output logic sof_out,
    output logic eof_out
);
    logic [31:0] frm [10];
    initial begin
        {valid_out, sof_out, eof_out, data_out} = 35'h0;
    end
    // words go out back to back; incoming crc is never checked, so word9 is filler
    task automatic send(input logic [23:0] dest, input logic [63:0] v, input logic csu);
        frm = '{{els_sync_pkg::ELS_RCTL ^ {7'h0, !csu}, dest}, {8'h00, els_sync_pkg::SERVER_ID},
                {8'h01, 24'h00_0000}, 32'h0, 32'hFFFF_FFFF, 32'h0, {els_sync_pkg::CSU_CODE, 24'h00_0000},
                v[63:32], v[31:0], ~v[31:0]};
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk_in);
            {valid_out, sof_out, eof_out} <= {1'b1, i == 0, i == 9};
            data_out <= frm[i];
        end
        @(posedge mclk_in);
        {valid_out, sof_out, eof_out} <= 3'b000;
        data_out <= ~frm[9];
    endtask
endmodule

// ==== sync_counter.sv ====
// module: local time base divider and n-bit loadable wrapping counter
module sync_counter (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic enable_in,
    input wire logic [15:0] div_in,
    input wire logic load_in,
    input wire logic [els_sync_pkg::COUNT_W-1:0] load_value_in,
    output logic [els_sync_pkg::COUNT_W-1:0] count_out,
    output logic tick_out
);
    logic [15:0] div_reg;
    logic [15:0] div_next;
    logic [els_sync_pkg::COUNT_W-1:0] count_reg;
    logic [els_sync_pkg::COUNT_W-1:0] count_next;
    logic tick_reg;
    logic tick_next;

    always_comb begin
        div_next = div_reg;
        tick_next = 1'b0;
        count_next = count_reg;
        if (enable_in) begin
            if (div_reg >= div_in) begin
                div_next = 16'h0000;
                tick_next = 1'b1;
            end else begin
                div_next = div_reg + 16'h0001;
            end
        end else begin
            div_next = 16'h0000;
        end
        // a load wins over the tick of the same cycle
        if (load_in) begin
            count_next = load_value_in;
        end else if (tick_reg) begin
            count_next = count_reg + 64'h0000_0000_0000_0001;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            div_reg <= 16'h0000;
            tick_reg <= 1'b0;
            count_reg <= 64'h0000_0000_0000_0000;
        end else begin
            div_reg <= div_next;
            tick_reg <= tick_next;
            count_reg <= count_next;
        end
    end

    assign count_out = count_reg;
    assign tick_out = tick_reg;
endmodule

// ==== tb.sv ====
// bench: self-checking run of the clock sync counter in client, fabric and server roles
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in = 1'b0, resetn_in = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd, delay, rxd, txd;
    logic hready, hresp, rxv, rxs, rxe, txv, txs, txe, icap, rcap;
    logic [63:0] cnt, v, c0;
    logic [23:0] dest;
    logic [31:0] txw [10];
    int n_tx = 0, err_total = 0, n_checks = 0, seed = 32'h9bd2;
    els_clock_sync_counter DUT (.mclk_in(mclk_in), .resetn_in(resetn_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .rx_valid_in(rxv), .rx_data_in(rxd),
        .rx_sof_in(rxs), .rx_eof_in(rxe), .tx_valid_out(txv), .tx_data_out(txd), .tx_sof_out(txs),
        .tx_eof_out(txe), .count_out(cnt), .init_capable_out(icap), .recip_capable_out(rcap));
    far_port u_far (.mclk_in(mclk_in), .valid_out(rxv), .data_out(rxd), .sof_out(rxs), .eof_out(rxe));
    initial begin
        forever #4 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        if (txv === 1'b1) begin
            if (txs === 1'b1) n_tx = 0;
            if (n_tx < 10) txw[n_tx] = txd;
            n_tx++;
        end
    end
    function automatic logic [31:0] crc(input logic [31:0] w [10]);
        logic [31:0] c;
        c = els_sync_pkg::CRC_INIT;
        for (int i = 0; i < 9; i++) for (int b = 31; b >= 0; b--)
            c = {c[30:0], 1'b0} ^ ((c[31] ^ w[i][b]) ? els_sync_pkg::CRC_POLY : 32'h0000_0000);
        return ~c;
    endfunction
    task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
        n_checks++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    // hold each phase until hready is seen high; no wait-state count assumed
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge mclk_in);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 24'h00_0000, a};
        do @(posedge mclk_in); while (hready !== 1'b1);
        {htrans, hwdata} <= {2'b00, wd};
        do @(posedge mclk_in); while (hready !== 1'b1);
        rd = hrdata;
        chk("hresp", 64'(hresp), 64'h0);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0000_0000);
        chk($sformatf("reg %h", a), 64'(rd), 64'(e));
    endtask
    task automatic finish_test();
        if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk_in);
        err_total++;
        finish_test();
    end
    initial begin
        repeat (16) @(posedge mclk_in);
        resetn_in <= 1'b1;
        @(posedge mclk_in);
        rchk(els_sync_pkg::OFS_PERIOD, els_sync_pkg::PERIOD_RESET);
        rchk(els_sync_pkg::OFS_QOS, 32'(els_sync_pkg::QOS_RESET));
        rchk(8'h28, 32'h0000_0000);
        dest = 24'($random(seed));
        delay = $random(seed);
        ahb(1'b1, els_sync_pkg::OFS_TICK_DIV, 32'h0000_0000);
        ahb(1'b1, els_sync_pkg::OFS_DELAY, delay);
        ahb(1'b1, els_sync_pkg::OFS_QOS, delay);
        rchk(els_sync_pkg::OFS_QOS, {8'h00, delay[23:0]});
        ahb(1'b1, els_sync_pkg::OFS_DEST_ID, 32'(dest));
        ahb(1'b1, els_sync_pkg::OFS_CTRL, 32'h0000_0004);
        rchk(els_sync_pkg::OFS_STATUS, 32'h0000_0008);
        v = {$random(seed), $random(seed)};
        u_far.send(24'($random(seed)), v, 1'b1);
        #1 chk("client load", cnt, v + 64'(delay));
        u_far.send(dest, 64'hFFFF_FFFF_FFFF_FFFF - 64'(delay), 1'b1);
        #1 chk("load top", cnt, 64'hFFFF_FFFF_FFFF_FFFF);
        @(posedge mclk_in);
        #1 chk("wrap", cnt, 64'h0);
        c0 = cnt;
        u_far.send(dest, v, 1'b0);
        #1 chk("non csu", cnt, c0 + 64'd11);
        // fabric keeping its own counter, then a plain relaying fabric
        for (int m = 0; m < 2; m++) begin
            ahb(1'b1, els_sync_pkg::OFS_CTRL, m ? 32'h0000_0005 : 32'h0000_000D);
            v = {$random(seed), $random(seed)};
            u_far.send(24'($random(seed)), v, 1'b1);
            #1;
            if (m == 0) chk("fabric load", cnt, v);
            repeat (5) @(posedge mclk_in);
            for (int i = 0; i < (m ? 10 : 7); i++)
                chk("relayed word", 64'(txw[i]), 64'(u_far.frm[i]));
            if (m == 0) chk("fabric payload", {txw[7], txw[8]}, v);
            if (m == 0) chk("fabric crc", 64'(txw[9]), 64'(crc(txw)));
        end
        ahb(1'b1, els_sync_pkg::OFS_PERIOD, 32'h0000_0040);
        ahb(1'b1, els_sync_pkg::OFS_CTRL, 32'h0000_0007);
        ahb(1'b0, els_sync_pkg::OFS_STATUS, 32'h0000_0000);
        chk("server caps", 64'({rd[3:2], rcap, icap}), 64'h5);
        for (int k = 0; k < 300 && txs !== 1'b1; k++) @(posedge mclk_in);
        c0 = cnt;
        repeat (12) @(posedge mclk_in);
        chk("server head", 64'(txw[0]), 64'({els_sync_pkg::ELS_RCTL, dest}));
        chk("server id", 64'(txw[1][23:0]), 64'(els_sync_pkg::SERVER_ID));
        chk("server time", 64'(c0 - {txw[7], txw[8]} <= 64'd4), 64'h1);
        chk("server crc", 64'(txw[9]), 64'(crc(txw)));
        ahb(1'b0, els_sync_pkg::OFS_CSU_COUNT, 32'h0000_0000);
        chk("csu count", 64'(rd != 32'h0000_0000), 64'h1);
        finish_test();
    end
endmodule
